// ---- include/hep_consts.vh ----
`ifndef HEP_CONSTS_VH
`define HEP_CONSTS_VH
// Mode field encodings
`define HEP_MODE_ENC      2'b00
`define HEP_MODE_EVT      2'b01
`define HEP_MODE_STIM     2'b10
`define HEP_MODE_TMR      2'b11
// Counter limits
`define HEP_CNT_W         24
`define HEP_CNT_MAX       24'hFFFFFF
`define HEP_EVT_MAX       24'h00FFFF
`define HEP_CNT_ZERO      24'h000000
// Reset values
`define HEP_CNT_RST       24'h000000
`define HEP_CAP_RST       24'h000000
`endif

// ---- hw/hep_sync.v ----
`timescale 1ns/1ps
// Two-flop synchroniser for the four sensor pins
module hep_sync (
   input  wire       clk,
   input  wire       rst,
   input  wire [3:0] pin_in,
   output reg  [3:0] pin_sync
);
   reg [3:0] meta;

   // First stage feeds only the second stage
   always @(posedge clk) begin
      if (rst) begin
         meta     <= 4'h0;
         pin_sync <= 4'h0;
      end else begin
         meta     <= pin_in;
         pin_sync <= meta;
      end
   end
endmodule // hep_sync

// ---- hw/hep_decode.v ----
`timescale 1ns/1ps
// Phase decoder: edge pulses and direction from synchronised phases
module hep_decode (
   input  wire       clk,
   input  wire       rst,
   input  wire       sensor_mode,
   input  wire       three_phase_select,
   input  wire [3:0] phase,
   output reg        edge_pulse,
   output reg        dir_cw,
   output reg        dir_valid
);
   reg  [3:0] prev;
   wire       p_a;
   wire       p_b;
   wire       p_c;
   wire       q_a;
   wire       q_b;
   wire       q_c;
   reg  [2:0] pos_now;
   reg  [2:0] pos_old;

   // Sensor modes read U,V,W on bits 2..0; encoder reads A,B
   assign p_a = phase[2];
   assign p_b = sensor_mode ? phase[1] : phase[1];
   assign p_c = sensor_mode ? phase[0] : phase[3];
   assign q_a = prev[2];
   assign q_b = sensor_mode ? prev[1] : prev[1];
   assign q_c = sensor_mode ? prev[0] : prev[3];

   // Gray position of 2-phase sequence 00,10,11,01 (A,B)
   function [2:0] pos2;
      input a;
      input b;
      begin
         pos2 = {1'b0, b, a ^ b};
      end
   endfunction

   // Position of 3-phase sequence 100,110,010,011,001,101; 7 is illegal
   function [2:0] pos3;
      input a;
      input b;
      input c;
      begin
         case ({a, b, c})
            3'b100:  pos3 = 3'h0;
            3'b110:  pos3 = 3'h1;
            3'b010:  pos3 = 3'h2;
            3'b011:  pos3 = 3'h3;
            3'b001:  pos3 = 3'h4;
            3'b101:  pos3 = 3'h5;
            default: pos3 = 3'h7;
         endcase
      end
   endfunction

   always @* begin
      if (three_phase_select) begin
         pos_now = pos3(p_a, p_b, p_c);
         pos_old = pos3(q_a, q_b, q_c);
      end else begin
         // Gray code already runs 0,1,2,3 in clockwise order
         pos_now = pos2(p_a, p_b);
         pos_old = pos2(q_a, q_b);
      end
   end

   // One step forward is clockwise, one step back counter-clockwise
   always @(posedge clk) begin
      if (rst) begin
         prev       <= 4'h0;
         edge_pulse <= 1'b0;
         dir_cw     <= 1'b0;
         dir_valid  <= 1'b0;
      end else begin
         prev       <= phase;
         edge_pulse <= 1'b0;
         dir_valid  <= 1'b0;
         if (pos_now != pos_old && pos_now != 3'h7 && pos_old != 3'h7) begin
            edge_pulse <= 1'b1;
            dir_valid  <= 1'b1;
            if (three_phase_select)
               dir_cw <= (pos_now == ((pos_old == 3'h5) ? 3'h0
                                       : pos_old + 3'h1));
            else
               dir_cw <= (pos_now[1:0] == pos_old[1:0] + 2'h1);
         end
      end
   end
endmodule // hep_decode

// ---- hw/hep_counter.v ----
`timescale 1ns/1ps
`include "hep_consts.vh"
// Functional notes
// - Timer-count mode times intervals between edge pulses
// - Timer-count: clock count, zero on pulse, wrap
// - Timer-count: edge pulse copies count to capture
// - Software capture bit copies count in timer-count and timer modes only
// - Direction flag one clockwise, zero counter-clockwise
// - Compare enable: interrupt when count equals compare
// - Run bit low clears direction flag
// - Timer-count direction change sets reverse error
// - Capture register cleared only by reset
// - Timer mode uses Z as trigger when enabled
// - Timer mode: Z edge select picks rising or falling
// - Timer clears on soft clear, max, compare, Z
// - Timer mode Z trigger copies count to capture
// - Two-bit mode field selects counting behaviour
// - Encoder: up clears at reload, down reloads
// - Event count spans zero to 0xFFFF
// - Quadrature order decides clockwise or counter-clockwise
// - Run low holds count; only clear zeroes
// - One shared 24-bit up/down counter
// - Interrupt enable gates every interrupt output
// - Timer-count compare hit before pulse is abnormal
module hep_counter (
   input  wire        clk,
   input  wire        rst,
   input  wire        pin_a,
   input  wire        pin_b,
   input  wire        pin_z,
   input  wire [1:0]  mode,
   input  wire        run_bit,
   input  wire        z_enable,
   input  wire        z_edge_select,
   input  wire        three_phase_select,
   input  wire        compare_enable,
   input  wire        int_enable,
   input  wire        soft_clear,
   input  wire        soft_capture,
   input  wire        rev_err_read,
   input  wire [23:0] compare_value,
   input  wire [23:0] reload_value,
   output reg  [23:0] count,
   output reg  [23:0] capture_register,
   output reg         direction_flag,
   output reg         reverse_error_flag,
   output reg         compare_flag,
   output reg         compare_irq,
   output reg         event_irq,
   output reg         capture_irq,
   output reg         abnormal_irq
);
   wire [3:0]  phase_sync;
   wire        edge_pulse;
   wire        dir_cw;
   wire        dir_valid;
   wire        sensor_mode;
   wire        z_now;
   reg         z_old;
   wire        z_trig;
   wire        cmp_hit;
   reg  [23:0] next_count;
   reg         next_cap_en;
   reg         stim_pending;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and phase decode
   ////////////////////////////////////////////////////////////////////////

   // U,V,W share the A,B,Z pins in sensor modes
   hep_sync u_sync (
      .clk      (clk),
      .rst      (rst),
      .pin_in   ({pin_z, pin_a, pin_b, pin_z}),
      .pin_sync (phase_sync)
   );

   assign sensor_mode = (mode == `HEP_MODE_EVT) || (mode == `HEP_MODE_STIM);

   hep_decode u_dec (
      .clk                (clk),
      .rst                (rst),
      .sensor_mode        (sensor_mode),
      .three_phase_select (three_phase_select),
      .phase              (phase_sync),
      .edge_pulse         (edge_pulse),
      .dir_cw             (dir_cw),
      .dir_valid          (dir_valid)
   );

   ////////////////////////////////////////////////////////////////////////
   // Z trigger detection
   ////////////////////////////////////////////////////////////////////////

   assign z_now = phase_sync[3];

   always @(posedge clk) begin
      if (rst)
         z_old <= 1'b0;
      else
         z_old <= z_now;
   end

   // Timer mode edge picked by select; encoder edge follows direction
   assign z_trig = z_enable && run_bit &&
      ((mode == `HEP_MODE_TMR) ?
         (z_edge_select ? (z_old && !z_now) : (!z_old && z_now)) :
       (mode == `HEP_MODE_ENC) ?
         (direction_flag ? (!z_old && z_now) : (z_old && !z_now)) :
       1'b0);

   assign cmp_hit = (count == compare_value);

   ////////////////////////////////////////////////////////////////////////
   // Counter next-state
   ////////////////////////////////////////////////////////////////////////

   // Soft clear wins over every counting action
   always @* begin
      next_count  = count;
      next_cap_en = 1'b0;
      if (soft_clear) begin
         next_count = `HEP_CNT_ZERO;
      end else if (run_bit) begin
         case (mode)
            `HEP_MODE_ENC: begin
               if (z_trig)
                  next_count = `HEP_CNT_ZERO;
               else if (edge_pulse && dir_cw)
                  next_count = (count == reload_value) ? `HEP_CNT_ZERO
                               : count + 24'h000001;
               else if (edge_pulse)
                  next_count = (count == `HEP_CNT_ZERO) ? reload_value
                               : count - 24'h000001;
            end
            `HEP_MODE_EVT: begin
               if (edge_pulse && dir_cw)
                  next_count = (count == `HEP_EVT_MAX) ? `HEP_CNT_ZERO
                               : count + 24'h000001;
               else if (edge_pulse)
                  next_count = (count == `HEP_CNT_ZERO) ? `HEP_EVT_MAX
                               : count - 24'h000001;
            end
            `HEP_MODE_STIM: begin
               if (edge_pulse) begin
                  next_count  = `HEP_CNT_ZERO;
                  next_cap_en = 1'b1;
               end else if (count == `HEP_CNT_MAX)
                  next_count = `HEP_CNT_ZERO;
               else
                  next_count = count + 24'h000001;
            end
            default: begin
               next_cap_en = z_trig;
               if (z_trig || (compare_enable && cmp_hit) ||
                   count == `HEP_CNT_MAX)
                  next_count = `HEP_CNT_ZERO;
               else
                  next_count = count + 24'h000001;
            end
         endcase
      end
   end

   // Single shared counter for all modes
   always @(posedge clk) begin
      if (rst)
         count <= `HEP_CNT_RST;
      else
         count <= next_count;
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture register
   ////////////////////////////////////////////////////////////////////////

   // Held across run changes; only reset zeroes it
   always @(posedge clk) begin
      if (rst)
         capture_register <= `HEP_CAP_RST;
      else if ((soft_capture && (mode == `HEP_MODE_STIM ||
                mode == `HEP_MODE_TMR)) || next_cap_en)
         capture_register <= count;
   end

   ////////////////////////////////////////////////////////////////////////
   // Direction and reverse error
   ////////////////////////////////////////////////////////////////////////

   // Set beats a read-clear in the same cycle so no reversal is lost
   always @(posedge clk) begin
      if (rst) begin
         direction_flag     <= 1'b0;
         reverse_error_flag <= 1'b0;
      end else begin
         if (!run_bit)
            direction_flag <= 1'b0;
         else if (dir_valid)
            direction_flag <= dir_cw;
         if (run_bit && dir_valid && mode == `HEP_MODE_STIM &&
             dir_cw != direction_flag && stim_pending)
            reverse_error_flag <= 1'b1;
         else if (rev_err_read)
            reverse_error_flag <= 1'b0;
      end
   end

   // First pulse after run only sets direction, not a reversal
   always @(posedge clk) begin
      if (rst)
         stim_pending <= 1'b0;
      else if (!run_bit)
         stim_pending <= 1'b0;
      else if (dir_valid)
         stim_pending <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts
   ////////////////////////////////////////////////////////////////////////

   // Pulses last one cycle; compare fires on the last cycle of a match, as count moves off it
   always @(posedge clk) begin
      if (rst) begin
         compare_irq  <= 1'b0;
         event_irq    <= 1'b0;
         capture_irq  <= 1'b0;
         abnormal_irq <= 1'b0;
         compare_flag <= 1'b0;
      end else begin
         compare_flag <= compare_enable && run_bit && cmp_hit &&
                         (next_count != count);
         compare_irq  <= int_enable && compare_enable && run_bit &&
                         cmp_hit && (next_count != count) &&
                         mode != `HEP_MODE_STIM;
         abnormal_irq <= int_enable && compare_enable && run_bit &&
                         cmp_hit && !edge_pulse &&
                         mode == `HEP_MODE_STIM;
         event_irq    <= int_enable && run_bit && edge_pulse;
         capture_irq  <= int_enable && (mode == `HEP_MODE_TMR) &&
                         z_trig;
      end
   end
endmodule // hep_counter

// ---- tb/hep_sensor_model.sv ----
`timescale 1ns/1ps
// Hall or quadrature phases, one table state per step request
module hep_sensor_model (
   input  wire clk,
   input  wire step,
   input  wire cw,
   input  wire three_ph,
   input  wire z_in,
   output wire pin_a,
   output wire pin_b,
   output wire pin_z
);
   reg  [2:0]  idx = 3'h0;
   wire [2:0]  last = three_ph ? 3'h5 : 3'h3;
   wire [17:0] tab3 = {3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
   wire [11:0] tab2 = {3'h2, 3'h6, 3'h4, 3'h0};
   wire [2:0]  uvw = three_ph ? tab3[idx * 3 +: 3] : tab2[idx * 3 +: 3];
   // Forward through the table is clockwise, backward counter-clockwise
   always @(posedge clk) begin
      if (step)
         idx <= cw ? ((idx == last) ? 3'h0 : idx + 3'h1)
                   : ((idx == 3'h0) ? last : idx - 3'h1);
   end
   assign pin_a = uvw[2];
   assign pin_b = uvw[1];
   // W shares the Z pin; the bench owns Z in two-phase setups
   assign pin_z = three_ph ? uvw[0] : z_in;
endmodule // hep_sensor_model

// ---- tb/hep_counter_assertions.sv ----
`timescale 1ns/1ps
// Port checks, one clock domain
module hep_counter_checker (
   input wire        clk,
   input wire        rst,
   input wire [1:0]  mode,
   input wire        run_bit,
   input wire        z_enable,
   input wire        compare_enable,
   input wire        int_enable,
   input wire        soft_clear,
   input wire        soft_capture,
   input wire [23:0] compare_value,
   input wire [23:0] count,
   input wire [23:0] capture_register,
   input wire        direction_flag,
   input wire        compare_irq,
   input wire        event_irq,
   input wire        capture_irq,
   input wire        abnormal_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_dir_stopped: assert property (
      !run_bit ##1 !run_bit |-> !direction_flag)
      else $error("direction set while stopped");
   chk_hold_count: assert property (
      !run_bit && !soft_clear |=> count == $past(count))
      else $error("count moved while stopped");
   chk_soft_clear: assert property (
      soft_clear |=> count == 24'h000000) else $error("clear missed");
   chk_timer_step: assert property (
      mode == 2'h3 && run_bit && !soft_clear && !compare_enable &&
      !z_enable && count != 24'hFFFFFF |=> count == $past(count) + 24'h000001)
      else $error("timer step wrong");
   chk_compare_hit: assert property (
      mode == 2'h3 && run_bit && compare_enable && int_enable && !soft_clear
      && count == compare_value |=> compare_irq && count == 24'h000000)
      else $error("compare match missed");
   chk_irq_gated: assert property (
      !int_enable ##1 !int_enable |->
      !(compare_irq || event_irq || capture_irq || abnormal_irq))
      else $error("interrupt while disabled");
   chk_irq_single: assert property (
      compare_irq |=> !compare_irq) else $error("compare irq too long");
   chk_soft_capture: assert property (
      soft_capture && mode[1] |=> capture_register == $past(count))
      else $error("soft capture wrong");
   chk_pulse_restart: assert property (
      mode == 2'h2 && run_bit && $past(run_bit) && event_irq |->
      count == 24'h000000 && capture_register == $past(count))
      else $error("interval capture wrong");
endmodule // hep_counter_checker
bind hep_counter hep_counter_checker u_hep_counter_checker (
   .clk(clk), .rst(rst), .mode(mode), .run_bit(run_bit),
   .z_enable(z_enable), .compare_enable(compare_enable),
   .int_enable(int_enable), .soft_clear(soft_clear),
   .soft_capture(soft_capture), .compare_value(compare_value),
   .count(count), .capture_register(capture_register),
   .direction_flag(direction_flag), .compare_irq(compare_irq),
   .event_irq(event_irq), .capture_irq(capture_irq),
   .abnormal_irq(abnormal_irq));

// ---- tb/hep_counter_bench.sv ----
`timescale 1ns/1ps
// Inputs change on the falling edge only
module hep_counter_bench;
   reg         clk = 1'b0, rst = 1'b1, run_bit = 1'b0, z_enable = 1'b0;
   reg         z_edge_select = 1'b0, three_phase_select = 1'b0, cw = 1'b1;
   reg         compare_enable = 1'b0, int_enable = 1'b0, soft_clear = 1'b0;
   reg         soft_capture = 1'b0, rev_err_read = 1'b0, step = 1'b0;
   reg         z_in = 1'b0, seen = 1'b0;
   reg  [1:0]  mode = 2'h3;
   reg  [23:0] prev = 24'h000000;
   integer     n_errors = 0, n_checks = 0, ticks = 0, k;
   wire        pin_a, pin_b, pin_z, direction_flag, reverse_error_flag;
   wire        compare_flag, compare_irq, event_irq, capture_irq, abnormal_irq;
   wire [23:0] count, capture_register;
   wire [3:0]  irqs = {abnormal_irq, compare_irq, capture_irq, event_irq};
   hep_counter u_hep_counter (
      .clk(clk), .rst(rst), .pin_a(pin_a), .pin_b(pin_b), .pin_z(pin_z),
      .mode(mode), .run_bit(run_bit), .z_enable(z_enable),
      .z_edge_select(z_edge_select), .three_phase_select(three_phase_select),
      .compare_enable(compare_enable), .int_enable(int_enable),
      .soft_clear(soft_clear), .soft_capture(soft_capture),
      .rev_err_read(rev_err_read), .compare_value(24'h000005),
      .reload_value(24'h0000FF), .count(count),
      .capture_register(capture_register), .direction_flag(direction_flag),
      .reverse_error_flag(reverse_error_flag), .compare_flag(compare_flag),
      .compare_irq(compare_irq), .event_irq(event_irq),
      .capture_irq(capture_irq), .abnormal_irq(abnormal_irq));
   hep_sensor_model u_hep_sensor_model (
      .clk(clk), .step(step), .cw(cw), .three_ph(three_phase_select),
      .z_in(z_in), .pin_a(pin_a), .pin_b(pin_b), .pin_z(pin_z));
   // 40 ns clock
   initial forever #20 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task test_done;
      begin
         $display("checks %0d errors %0d", n_checks, n_errors);
         if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task chk(input [95:0] what, input [23:0] exp, input [23:0] got);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   // Bounded wait; prev keeps the count just before the interrupt edge
   task wait_ev(input integer w);
      integer i;
      begin
         i = 0;
         do begin
            prev = count;
            @(negedge clk);
            i = i + 1;
         end while (irqs[w] !== 1'b1 && i < 200);
         chk("irq", 24'h000001, {23'h0, irqs[w]});
      end
   endtask
   task clr;
      begin
         soft_clear = 1'b1;
         @(negedge clk);
         soft_clear = 1'b0;
      end
   endtask
   task pulse(input d);
      begin
         cw = d;
         step = 1'b1;
         @(negedge clk);
         step = 1'b0;
         wait_ev(0);
         chk("count", 24'h000000, count);
         chk("interval", prev, capture_register);
      end
   endtask
   task test_timer;
      begin
         run_bit = 1'b1;
         clr;
         repeat (10) @(negedge clk);
         chk("count", 24'h00000A, count);
         soft_capture = 1'b1;
         @(negedge clk);
         soft_capture = 1'b0;
         run_bit = 1'b0;
         repeat (5) @(negedge clk);
         chk("capture", 24'h00000A, capture_register);
         chk("held", 24'h00000B, count);
         chk("dir", 24'h000000, {23'h0, direction_flag});
         run_bit = 1'b1;
         repeat (2) @(negedge clk);
         chk("resume", 24'h00000D, count);
         $display("timer test done");
      end
   endtask
   task test_compare;
      begin
         clr;
         compare_enable = 1'b1;
         int_enable = 1'b1;
         wait_ev(2);
         chk("count", 24'h000000, count);
         chk("last", 24'h000005, prev);
         chk("flag", 24'h000001, {23'h0, compare_flag});
         @(negedge clk);
         chk("irq width", 24'h000000, {23'h0, compare_irq});
         int_enable = 1'b0;
         repeat (20) @(negedge clk) seen = seen | compare_irq;
         chk("gated", 24'h000000, {23'h0, seen});
         compare_enable = 1'b0;
         $display("compare test done");
      end
   endtask
   task test_z;
      begin
         int_enable = 1'b1;
         z_enable = 1'b1;
         for (k = 0; k < 2; k = k + 1) begin
            z_edge_select = k[0];
            repeat (8) @(negedge clk);
            z_in = ~z_in;
            wait_ev(1);
            chk("count", 24'h000000, count);
            chk("capture", prev, capture_register);
         end
         z_enable = 1'b0;
         prev = capture_register;
         z_in = 1'b1;
         repeat (8) @(negedge clk);
         chk("no trigger", prev, capture_register);
         $display("z test done");
      end
   endtask
   task test_sensor;
      begin
         mode = 2'h2;
         for (k = 0; k < 4; k = k + 1) pulse(1'b1);
         chk("dir", 24'h000001, {23'h0, direction_flag});
         chk("rev", 24'h000000, {23'h0, reverse_error_flag});
         pulse(1'b0);
         @(negedge clk);
         chk("dir", 24'h000000, {23'h0, direction_flag});
         chk("rev", 24'h000001, {23'h0, reverse_error_flag});
         rev_err_read = 1'b1;
         @(negedge clk);
         rev_err_read = 1'b0;
         chk("rev", 24'h000000, {23'h0, reverse_error_flag});
         // Phase count changes only while stopped, so the switch is no step
         run_bit = 1'b0;
         three_phase_select = 1'b1;
         repeat (6) @(negedge clk);
         run_bit = 1'b1;
         for (k = 0; k < 6; k = k + 1) pulse(1'b1);
         chk("dir", 24'h000001, {23'h0, direction_flag});
         compare_enable = 1'b1;
         wait_ev(3);
         chk("late", 24'h000005, prev);
         compare_enable = 1'b0;
         $display("sensor test done");
      end
   endtask
   task test_modes;
      begin
         for (k = 0; k < 2; k = k + 1) begin
            mode = k[1:0];
            clr;
            repeat (10) @(negedge clk);
            chk("still", 24'h000000, count);
            cw = 1'b0;
            step = 1'b1;
            @(negedge clk);
            step = 1'b0;
            wait_ev(0);
            chk("wrap", k ? 24'h00FFFF : 24'h0000FF, count);
         end
         $display("mode test done");
      end
   endtask
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      test_timer;
      test_compare;
      test_z;
      test_sensor;
      test_modes;
      test_done;
   end
   // Hang guard; the full run needs well under a thousand cycles
   always @(posedge clk) begin
      ticks = ticks + 1;
      if (ticks == 3000) begin
         n_errors = n_errors + 1;
         test_done;
      end
   end
endmodule // hep_counter_bench
